// ### src/hpsd_pkg.sv
// Package: pin vector layout and timing constants for the host port strobe decoder
package hpsd_pkg;
  // ************************************************************
  // Synchronised pin vector layout
  // ************************************************************
  localparam int PIN_W = 21;
  localparam int POS_CFG = 0;
  localparam int POS_STYLE = 1;
  localparam int POS_WR = 2;
  localparam int POS_RD = 3;
  localparam int POS_ALE = 4;
  localparam int POS_CS = 5;
  localparam int POS_ADDR = 6;
  localparam int POS_DATA = 13;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // ************************************************************
  // Bus style encoding and reset values
  // ************************************************************
  localparam logic STYLE_SEPARATE = 1'b0;
  localparam logic STYLE_DIR_STROBE = 1'b1;
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES = 2;
  // Cycles after reset release until the pin synchroniser holds real values
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
endpackage : hpsd_pkg

// ### src/hpsd_sync.sv
// Two flip-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/10ps
module hpsd_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule : hpsd_sync

// ### src/hpsd_top.sv
// Mode select and strobe decoder for the shared parallel host port pins
//
// Function
// [RULE1] Select pin low: host register interface enabled, configuration by register writes.
// [RULE2] Select pin high or floating: host interface disabled, pins configure device.
// [RULE3] Separate-strobe style: write strobe low enables data bus input buffers.
// [RULE4] Separate-strobe style: data captured into addressed register on write strobe rise.
// [RULE5] Direction style: direction high at data strobe fall means read.
// [RULE6] Direction style: direction low at data strobe fall means write.
// [RULE7] Separate-strobe style: read strobe low drives addressed register onto data bus.
// [RULE8] Read strobe released: data bus returns to high impedance.
// [RULE9] Hardware mode: write pin commands channel 0, read pin channel 1 all ones.
// [RULE10] Separate-strobe style: address latched on falling edge of latch enable.
// [RULE11] Host asserts chip select low for every register access.
// [RULE12] Direction style: host holds address strobe low from address valid onward.
// [RULE13] Command high sends unframed all ones; low sends normal traffic.
// [RULE14] Bus style pin sampled once after reset, then held constant.
`timescale 1ns/10ps
module hpsd_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Static configuration pins
  input wire logic config_source_select,
  input wire logic bus_style_pin,
  // Shared strobe pins
  input wire logic write_or_dir_pin,
  input wire logic read_or_data_strobe_pin,
  input wire logic addr_latch_pin,
  input wire logic chip_select_n,
  // Address and data bus pins
  input wire logic [6:0] addr_pin,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic data_in_en,
  // Register file side
  input wire logic [7:0] reg_rd_data,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_pulse,
  // Mode and channel commands
  output logic host_if_en,
  output logic tx_all_ones_cmd_ch0,
  output logic tx_all_ones_cmd_ch1
);
  // ************************************************************
  // Pin synchronisation and edge detection
  // ************************************************************
  logic [hpsd_pkg::PIN_W-1:0] pins_raw;
  logic [hpsd_pkg::PIN_W-1:0] pins_s;
  logic [hpsd_pkg::PIN_W-1:0] pins_prev_reg;

  function automatic logic fell(input logic cur, input logic prev);
    fell = prev & ~cur;
  endfunction : fell

  function automatic logic rose(input logic cur, input logic prev);
    rose = cur & ~prev;
  endfunction : rose

  assign pins_raw = {data_in, addr_pin, chip_select_n, addr_latch_pin, read_or_data_strobe_pin,
                     write_or_dir_pin, bus_style_pin, config_source_select};

  hpsd_sync #(.WIDTH(hpsd_pkg::PIN_W)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(pins_raw),
    .pin_sync(pins_s)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pins_prev_reg <= '0;
    end else begin
      pins_prev_reg <= pins_s;
    end
  end

  wire cfg_s = pins_s[hpsd_pkg::POS_CFG];
  wire style_s = pins_s[hpsd_pkg::POS_STYLE];
  wire wr_s = pins_s[hpsd_pkg::POS_WR];
  wire rd_s = pins_s[hpsd_pkg::POS_RD];
  wire cs_n_s = pins_s[hpsd_pkg::POS_CS];
  wire [6:0] addr_s = pins_s[hpsd_pkg::POS_ADDR +: hpsd_pkg::ADDR_W];
  wire [7:0] data_s = pins_s[hpsd_pkg::POS_DATA +: hpsd_pkg::DATA_W];
  wire wr_fall = fell(wr_s, pins_prev_reg[hpsd_pkg::POS_WR]);
  wire wr_rise = rose(wr_s, pins_prev_reg[hpsd_pkg::POS_WR]);
  wire rd_fall = fell(rd_s, pins_prev_reg[hpsd_pkg::POS_RD]);
  wire rd_rise = rose(rd_s, pins_prev_reg[hpsd_pkg::POS_RD]);
  // Latch enable falls in separate style, address strobe falls in direction style
  wire ale_fall = fell(pins_s[hpsd_pkg::POS_ALE], pins_prev_reg[hpsd_pkg::POS_ALE]);

  // ************************************************************
  // Bus style capture after reset
  // ************************************************************
  // Sampled once: a style change mid-access would corrupt the strobe meaning
  logic [1:0] settle_cnt_reg;
  logic style_reg;
  logic ready_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      settle_cnt_reg <= 2'h0;
      style_reg <= hpsd_pkg::STYLE_SEPARATE;
      ready_reg <= 1'b0;
    end else if (!ready_reg) begin
      settle_cnt_reg <= settle_cnt_reg + 2'h1;
      if (settle_cnt_reg == hpsd_pkg::SETTLE_CYCLES) begin
        style_reg <= style_s; // RULE14
        ready_reg <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Mode and access decode
  // ************************************************************
  wire host_mode = ready_reg & ~cfg_s; // RULE1 RULE2
  wire hw_mode = ready_reg & cfg_s;
  wire sep_style = (style_reg == hpsd_pkg::STYLE_SEPARATE);
  wire sel = host_mode & ~cs_n_s; // RULE11
  logic dir_reg;
  logic strobe_active_reg;

  wire sep_wr_done = sel & sep_style & wr_rise;
  wire dir_start = sel & ~sep_style & rd_fall;
  wire dir_wr_done = sel & ~sep_style & strobe_active_reg & rd_rise & (dir_reg == hpsd_pkg::DIR_WRITE);
  wire sep_read = sel & sep_style & ~rd_s;
  wire dir_read = sel & ~sep_style & strobe_active_reg & ~rd_s & (dir_reg == hpsd_pkg::DIR_READ);
  wire read_active = sep_read | dir_read;
  wire in_buf_en = sel & ((sep_style & ~wr_s) | (~sep_style & strobe_active_reg & ~dir_reg));

  // ************************************************************
  // Address latch and direction capture
  // ************************************************************
  logic [6:0] addr_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= hpsd_pkg::ADDR_RST;
    end else if (host_mode && ale_fall) begin
      addr_reg <= addr_s; // RULE10 RULE12
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dir_reg <= hpsd_pkg::DIR_READ;
      strobe_active_reg <= 1'b0;
    end else if (dir_start) begin
      dir_reg <= wr_s; // RULE5 RULE6
      strobe_active_reg <= 1'b1;
    end else if (rd_s || !sel) begin
      strobe_active_reg <= 1'b0;
    end
  end

  // ************************************************************
  // Register file access
  // ************************************************************
  logic [7:0] wr_data_reg;
  logic wr_pulse_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_data_reg <= hpsd_pkg::DATA_RST;
      wr_pulse_reg <= 1'b0;
    end else begin
      wr_pulse_reg <= sep_wr_done | dir_wr_done; // RULE4 RULE6
      if (sep_wr_done || dir_wr_done) begin
        wr_data_reg <= data_s; // RULE4
      end
    end
  end

  // ************************************************************
  // Data bus drive
  // ************************************************************
  logic [7:0] dout_reg;
  logic oe_reg;
  logic in_en_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dout_reg <= hpsd_pkg::DATA_RST;
      oe_reg <= 1'b0;
      in_en_reg <= 1'b0;
    end else begin
      oe_reg <= read_active; // RULE7 RULE8 RULE5
      dout_reg <= read_active ? reg_rd_data : hpsd_pkg::DATA_RST; // RULE7
      in_en_reg <= in_buf_en; // RULE3
    end
  end

  // ************************************************************
  // Hardware mode channel commands
  // ************************************************************
  logic all_ones0_reg;
  logic all_ones1_reg;
  logic host_en_reg;

  // Forced low in host mode so strobe traffic never reaches the transmitters
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      all_ones0_reg <= 1'b0;
      all_ones1_reg <= 1'b0;
      host_en_reg <= 1'b0;
    end else begin
      all_ones0_reg <= hw_mode & wr_s; // RULE9 RULE13
      all_ones1_reg <= hw_mode & rd_s; // RULE9 RULE13
      host_en_reg <= host_mode; // RULE1 RULE2
    end
  end

  assign data_out = dout_reg;
  assign data_oe = oe_reg;
  assign data_in_en = in_en_reg;
  assign reg_addr = addr_reg;
  assign reg_wr_data = wr_data_reg;
  assign reg_wr_pulse = wr_pulse_reg;
  assign host_if_en = host_en_reg;
  assign tx_all_ones_cmd_ch0 = all_ones0_reg;
  assign tx_all_ones_cmd_ch1 = all_ones1_reg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  host_enable_a: assert property (host_if_en |-> $past(!cfg_s && ready_reg)) // RULE1
    else $error("Host interface enabled while select was high");
  hw_disable_a: assert property (hw_mode |=> !host_if_en && !reg_wr_pulse && !data_oe) // RULE2
    else $error("Host interface active in hardware mode");
  in_buffer_a: assert property (sel && sep_style && !wr_s |=> data_in_en) // RULE3
    else $error("Input buffers not enabled during write strobe");
  sep_write_a: assert property (sep_wr_done |=> reg_wr_pulse && reg_wr_data == $past(data_s)) // RULE4
    else $error("Write strobe rise did not capture data");
  dir_read_a: assert property (dir_start && wr_s ##1 (sel && !rd_s) |=> data_oe) // RULE5
    else $error("Direction read did not drive bus");
  dir_write_a: assert property (dir_start && !wr_s |=> !data_oe) // RULE6
    else $error("Direction write drove the bus");
  sep_read_a: assert property (sep_read |=> data_oe && data_out == $past(reg_rd_data)) // RULE7
    else $error("Read strobe did not drive register contents");
  release_a: assert property (host_mode && rd_s |=> !data_oe) // RULE8
    else $error("Data bus not released after read strobe");
  ones_map_a: assert property (hw_mode |=> tx_all_ones_cmd_ch0 == $past(wr_s) && // RULE9 RULE13
    tx_all_ones_cmd_ch1 == $past(rd_s))
    else $error("All ones command does not follow strobe pins");
  addr_latch_a: assert property (host_mode && ale_fall |=> reg_addr == $past(addr_s)) // RULE10 RULE12
    else $error("Address not latched on strobe fall");
  style_hold_a: assert property (ready_reg |=> $stable(style_reg)) // RULE14
    else $error("Bus style changed after capture");

  sep_write_c: cover property (sep_wr_done ##1 reg_wr_pulse);
  sep_read_c: cover property (sep_read [*3] ##1 !sep_read ##1 !data_oe);
  dir_write_c: cover property (dir_start && !wr_s ##[1:20] dir_wr_done);
  hw_ones_c: cover property (hw_mode && tx_all_ones_cmd_ch0 && tx_all_ones_cmd_ch1);
endmodule : hpsd_top

// ### verif/hpsd_host_model.sv
// Host processor model driving the shared parallel port pins
`timescale 1ns/10ps
module hpsd_host_model (
  // Clock
  input wire logic ref_clk,
  // Host driven pins
  output logic write_or_dir_pin,
  output logic read_or_data_strobe_pin,
  output logic addr_latch_pin,
  output logic chip_select_n,
  output logic [6:0] addr_pin,
  output logic [7:0] data_in,
  // Device side of the data bus
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic data_in_en
);
  logic drive_en = 1'b0;
  logic [7:0] wr_val = 8'h00;
  logic [7:0] noise = 8'h5a;
  initial begin
    write_or_dir_pin = 1'b1;
    read_or_data_strobe_pin = 1'b1;
    addr_latch_pin = 1'b0;
    chip_select_n = 1'b1;
    addr_pin = 7'h00;
  end
  // Undriven bus must not keep showing its last value
  always @(posedge ref_clk) noise <= ~noise;
  assign data_in = drive_en ? wr_val : (data_oe ? data_out : noise);
  task automatic set_pins(input logic w, input logic r, input logic l);
    @(posedge ref_clk);
    write_or_dir_pin <= w;
    read_or_data_strobe_pin <= r;
    addr_latch_pin <= l;
  endtask : set_pins
  // One access in either bus style; f is the mid-strobe flag, g the flags after release
  task automatic access(input logic dir, input logic is_rd, input logic cs_n, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] q, output logic f, output logic g);
    @(posedge ref_clk);
    addr_pin <= a;
    chip_select_n <= cs_n;
    addr_latch_pin <= !dir;
    wr_val <= d;
    drive_en <= !is_rd;
    repeat (3) @(posedge ref_clk);
    addr_latch_pin <= 1'b0;
    if (dir) write_or_dir_pin <= is_rd;
    repeat (3) @(posedge ref_clk);
    if (dir || is_rd) read_or_data_strobe_pin <= 1'b0;
    else write_or_dir_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    q = data_out;
    f = (is_rd || dir) ? data_oe : data_in_en;
    @(posedge ref_clk);
    read_or_data_strobe_pin <= 1'b1;
    if (!dir) write_or_dir_pin <= 1'b1;
    // Data held well past the strobe rise
    repeat (6) @(posedge ref_clk);
    g = data_oe | data_in_en;
    drive_en <= 1'b0;
    chip_select_n <= 1'b1;
    addr_latch_pin <= dir;
  endtask : access
endmodule : hpsd_host_model

// ### verif/test_host_port_strobe_decode.sv
// Self-checking bench for the host port strobe decoder
`timescale 1ns/10ps
module test_host_port_strobe_decode;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic config_source_select = 1'b0;
  logic bus_style_pin = 1'b0;
  logic w, r, l, csn, data_oe, data_in_en, reg_wr_pulse, host_if_en, ch0, ch1, f, g, b0, b1;
  logic [6:0] addr_pin, reg_addr, last_a, a;
  logic [7:0] data_in, data_out, reg_wr_data, reg_rd_data, last_d, d, q;
  logic [7:0] regs [0:127];
  logic [7:0] exp_regs [0:127];
  int seed = 32'h5cca;
  int mismatches = 0;
  int total_checks = 0;
  int wr_count = 0;
  int n;
  always #5 ref_clk = ~ref_clk;
  assign reg_rd_data = regs[reg_addr];
  always @(posedge ref_clk) begin
    if (reg_wr_pulse === 1'b1) begin
      regs[reg_addr] <= reg_wr_data;
      wr_count <= wr_count + 1;
      last_a <= reg_addr;
      last_d <= reg_wr_data;
    end
  end
  hpsd_host_model u_host (.ref_clk(ref_clk), .write_or_dir_pin(w), .read_or_data_strobe_pin(r),
    .addr_latch_pin(l), .chip_select_n(csn), .addr_pin(addr_pin), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .data_in_en(data_in_en));
  hpsd_top u_dut (.ref_clk(ref_clk), .rst(rst), .config_source_select(config_source_select),
    .bus_style_pin(bus_style_pin), .write_or_dir_pin(w), .read_or_data_strobe_pin(r),
    .addr_latch_pin(l), .chip_select_n(csn), .addr_pin(addr_pin), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .data_in_en(data_in_en), .reg_rd_data(reg_rd_data),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_pulse(reg_wr_pulse),
    .host_if_en(host_if_en), .tx_all_ones_cmd_ch0(ch0), .tx_all_ones_cmd_ch1(ch1));
  function automatic logic exp_cmd(input logic hw, input logic pin);
    return hw & pin;
  endfunction : exp_cmd
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  // Style pin is only taken after reset, so each phase starts with one
  task automatic do_reset(input logic cfg, input logic sty);
    u_host.set_pins(1'b1, 1'b1, sty);
    rst <= 1'b1;
    config_source_select <= cfg;
    bus_style_pin <= sty;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask : do_reset
  task automatic one_write(input logic dir, input logic cs_n, input logic [6:0] wa, input logic [7:0] wd);
    n = wr_count;
    u_host.access(dir, 1'b0, cs_n, wa, wd, q, f, g);
    if (!cs_n) exp_regs[wa] = wd;
    check(8'(wr_count - n), {7'h00, !cs_n});
    if (!cs_n) begin
      check({7'h00, f}, {7'h00, !dir});
      check({1'b0, last_a}, {1'b0, wa});
      check(last_d, wd);
    end
    check({7'h00, g}, 8'h00);
  endtask : one_write
  task automatic one_read(input logic dir, input logic [6:0] ra);
    u_host.access(dir, 1'b1, 1'b0, ra, 8'h00, q, f, g);
    check(q, exp_regs[ra]);
    check({7'h00, f}, 8'h01);
    check({7'h00, g}, 8'h00);
  endtask : one_read
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
  initial begin
    for (int i = 0; i < 128; i++) begin
      regs[i] = 8'h00;
      exp_regs[i] = 8'h00;
    end
    do_reset(1'b0, 1'b0);
    check({7'h00, host_if_en}, 8'h01);
    check({6'h00, ch1, ch0}, 8'h00);
    for (int i = 0; i < 10; i++) begin
      a = (i == 0) ? 7'h7f : 7'($random(seed));
      d = (i == 1) ? 8'hff : (i == 2) ? 8'h00 : 8'($random(seed));
      one_write(1'b0, 1'b0, a, d);
      one_read(1'b0, a);
    end
    // Deselected write must leave the register alone
    one_write(1'b0, 1'b1, 7'h7f, 8'h3c);
    one_read(1'b0, 7'h7f);
    $display("test separate strobes done");
    do_reset(1'b0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      a = 7'($random(seed));
      one_write(1'b1, 1'b0, a, 8'($random(seed)));
      one_read(1'b1, a);
    end
    $display("test direction strobe done");
    do_reset(1'b1, 1'b0);
    check({7'h00, host_if_en}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      b0 = 1'($random(seed));
      b1 = 1'($random(seed));
      u_host.set_pins(b0, b1, 1'($random(seed)));
      repeat (5) @(posedge ref_clk);
      check({6'h00, ch1, ch0}, {6'h00, exp_cmd(1'b1, b1), exp_cmd(1'b1, b0)});
    end
    n = wr_count;
    u_host.access(1'b0, 1'b0, 1'b0, 7'h05, 8'ha5, q, f, g);
    check(8'(wr_count - n), 8'h00);
    check({7'h00, data_oe}, 8'h00);
    $display("test hardware mode done");
    complete_run();
  end
endmodule : test_host_port_strobe_decode
